// ---- common/smtc_pkg.sv ----
// shared constants of the supply monitor and trim configuration block
package smtc_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] SMTC_IDX_MAIN_CTRL = 6'h09;
  localparam logic [5:0] SMTC_IDX_BAT_CTRL = 6'h0a;
  localparam logic [5:0] SMTC_IDX_TRIM = 6'h0b;
  localparam logic [5:0] SMTC_IDX_STATUS = 6'h0c;
  localparam logic [5:0] SMTC_IDX_MASK = 6'h0d;
  localparam logic [5:0] SMTC_IDX_STAMP_M2B = 6'h0e;
  localparam logic [5:0] SMTC_IDX_STAMP_B2M = 6'h0f;
  localparam logic [5:0] SMTC_IDX_LEVEL = 6'h10;
  localparam int SMTC_ADDR_W = 8;
  localparam int SMTC_DATA_W = 32;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SMTC_CLR_STAMPS_POS = 7;
  localparam int SMTC_DISCONNECT_POS = 6;
  localparam int SMTC_FIRST_SEL_LSB = 3;
  localparam int SMTC_SECOND_SEL_LSB = 0;
  localparam int SMTC_MAIN_SEL_LSB = 0;
  localparam int SMTC_ATRIM_LSB = 0;
  localparam int SMTC_DTRIM_LSB = 6;
  // status / mask bit positions
  localparam int SMTC_ST_MAIN_LOW = 0;
  localparam int SMTC_ST_BAT_FIRST = 1;
  localparam int SMTC_ST_BAT_SECOND = 2;
  localparam int SMTC_ST_TO_BACKUP = 3;
  localparam int SMTC_ST_TO_MAIN = 4;
  localparam int SMTC_ST_W = 5;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] SMTC_MAIN_CTRL_RST = 8'h00;
  localparam logic [7:0] SMTC_BAT_CTRL_RST = 8'h00;
  localparam logic [4:0] SMTC_MASK_RST = 5'h00;
  localparam logic [5:0] SMTC_ATRIM_PRESET = 6'h20;
  localparam logic [1:0] SMTC_DTRIM_PRESET = 2'h0;
  localparam int SMTC_SYNC_STAGES = 2;

  // ****************************************************************
  // threshold tables in millivolts, zero marks a reserved code
  // ****************************************************************
  // 2295 2550 2805 3060 4250 4675 mV
  localparam logic [12:0] SMTC_MAIN_MV [8] = '{13'h08f7, 13'h09f6,
    13'h0af5, 13'h0bf4, 13'h109a, 13'h1243, 13'h0000, 13'h0000};
  // 2125 2295 2550 2805 3060 4250 4675 mV
  localparam logic [12:0] SMTC_FIRST_MV [8] = '{13'h084d, 13'h08f7,
    13'h09f6, 13'h0af5, 13'h0bf4, 13'h109a, 13'h1243, 13'h0000};
  // 1875 2025 2250 2475 2700 3750 4125 mV
  localparam logic [12:0] SMTC_SECOND_MV [8] = '{13'h0753, 13'h07e9,
    13'h08ca, 13'h09ab, 13'h0a8c, 13'h0ea6, 13'h101d, 13'h0000};

  // ****************************************************************
  // trim arithmetic in half-ppm units
  // ****************************************************************
  localparam logic signed [7:0] SMTC_ATRIM_ZERO = 8'sh40;
  localparam logic signed [7:0] SMTC_DTRIM_STEP = 8'sh3d;
  localparam logic signed [7:0] SMTC_SPAN_MAX = 8'sh7d;
  localparam logic signed [7:0] SMTC_SPAN_MIN = -8'sh7b;

  typedef enum logic [1:0] {SMTC_TBL_MAIN, SMTC_TBL_FIRST,
    SMTC_TBL_SECOND} smtc_table_t;
endpackage : smtc_pkg

// ---- core/smtc_trip_decode.sv ----
// trip selector to threshold decoder, registered
module smtc_trip_decode
  import smtc_pkg::*;
#(
  parameter smtc_table_t TABLE = SMTC_TBL_MAIN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] tripSel,
  output logic [12:0] thresholdMv_r,
  output logic thresholdValid_r
);
  import smtc_pkg::*;

  // ****************************************************************
  // table lookup
  // ****************************************************************
  logic [12:0] tableMv;
  logic reservedCode;
  assign tableMv = (TABLE == SMTC_TBL_MAIN) ? SMTC_MAIN_MV[tripSel] :
    (TABLE == SMTC_TBL_FIRST) ? SMTC_FIRST_MV[tripSel] :
    SMTC_SECOND_MV[tripSel];
  // R17: reserved codes
  assign reservedCode = (TABLE == SMTC_TBL_MAIN) ? (tripSel[2:1] == 2'h3) :
    (tripSel == 3'h7);

  // register threshold, reserved gives no level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thresholdMv_r <= 13'h0000;
      thresholdValid_r <= 1'b0;
    end else begin
      thresholdMv_r <= reservedCode ? 13'h0000 : tableMv;
      thresholdValid_r <= !reservedCode;
    end
  end

  reserved_code_a: assert property ( // R17
    @(posedge clk) disable iff (!rst_n)
    reservedCode |=> !thresholdValid_r && thresholdMv_r == 13'h0000)
    else $error("reserved trip code produced a threshold");
endmodule // smtc_trip_decode

// ---- core/smtc_trim.sv ----
// combined analog and digital trim evaluation
module smtc_trim
  import smtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] analogTrimCode,
  input wire logic [1:0] coarseDigitalTrimCode,
  output logic signed [7:0] trimHalfPpm_r,
  output logic insertPulse_r,
  output logic skipPulse_r
);
  import smtc_pkg::*;

  // ****************************************************************
  // offset arithmetic
  // ****************************************************************
  logic signed [7:0] analogPart;
  logic signed [7:0] digitalPart;
  // analog: code 0 is +32 ppm, each step -1 ppm
  assign analogPart = SMTC_ATRIM_ZERO - $signed({1'b0, analogTrimCode, 1'b0});
  // R12: 01 +30.5, 11 -30.5, 10 zero, 00 disabled
  assign digitalPart = (coarseDigitalTrimCode == 2'h1) ? SMTC_DTRIM_STEP :
    (coarseDigitalTrimCode == 2'h3) ? -SMTC_DTRIM_STEP : 8'sh00;

  // R10: digital part inserts or skips pulses, analog part loads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trimHalfPpm_r <= 8'sh00;
      insertPulse_r <= 1'b0;
      skipPulse_r <= 1'b0;
    end else begin
      trimHalfPpm_r <= analogPart + digitalPart;
      insertPulse_r <= (coarseDigitalTrimCode == 2'h1);
      skipPulse_r <= (coarseDigitalTrimCode == 2'h3);
    end
  end

  trim_span_a: assert property ( // R11
    @(posedge clk) disable iff (!rst_n)
    ##1 (trimHalfPpm_r <= SMTC_SPAN_MAX && trimHalfPpm_r >= SMTC_SPAN_MIN))
    else $error("trim outside +62.5 to -61.5 ppm");
  trim_step_a: assert property ( // R12
    @(posedge clk) disable iff (!rst_n)
    (coarseDigitalTrimCode == 2'h3) |=> skipPulse_r && !insertPulse_r)
    else $error("negative coarse trim did not skip pulses");
endmodule // smtc_trim

// ---- core/smtc_supply_cfg.sv ----
// supply monitor configuration, status and trim register bank
// Behaviour
// R1: writing one to clear bit zeroes both switchover stamps
// R2: clear bit resets to zero; one is its active setting
// R3: main trip selector picks brownout threshold 2.295 to 4.675 V
// R4: main supply below threshold sets the main supply low flag
// R5: disconnect bit set to one requests battery disconnection
// R6: main supply falling then rising clears disconnect bit, reconnects
// R7: first battery selector bits 5..3 map seven levels 2.125 to 4.675
// R8: second battery selector bits 2..0 map levels 1.875 to 4.125
// R9: trim codes load from presets at power-up, writes ignored
// R10: digital trim skips or inserts pulses, analog trim adjusts load
// R11: combined trim spans +62.5 ppm down to -61.5 ppm
// R12: coarse trim 00 off, 01 +30.5, 10 zero, 11 -30.5 ppm
// R13: host changes coarse trim only while temp sensing disabled
// R14: battery check each minute at second 59, or on sense trigger
// R15: first battery flag follows comparison at each detection cycle
// R16: main control bits 6..3 read zero, writes ignored
// R17: unlisted trip codes are reserved, with no threshold
module smtc_supply_cfg
  import smtc_pkg::*;
#(
  parameter logic [5:0] ATRIM_PRESET = SMTC_ATRIM_PRESET,
  parameter logic [1:0] DTRIM_PRESET = SMTC_DTRIM_PRESET
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [smtc_pkg::SMTC_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [smtc_pkg::SMTC_DATA_W-1:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [smtc_pkg::SMTC_DATA_W-1:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic mainSupplyGood,
  input wire logic mainBelowTrip,
  input wire logic batBelowFirstTrip,
  input wire logic batBelowSecondTrip,
  input wire logic secondsAt59,
  input wire logic tempSenseTrigger,
  input wire logic [31:0] timeNow,
  output logic [12:0] mainTripMv,
  output logic mainTripValid,
  output logic [12:0] firstTripMv,
  output logic firstTripValid,
  output logic [12:0] secondTripMv,
  output logic secondTripValid,
  output logic batteryDisconnect,
  output logic signed [7:0] trimHalfPpm,
  output logic insertPulse,
  output logic skipPulse,
  output logic irq
);
  import smtc_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] pinRaw;
  logic [3:0] syncA_r;
  logic [3:0] syncB_r;
  logic mainGoodDly_r;
  assign pinRaw = {batBelowSecondTrip, batBelowFirstTrip, mainBelowTrip,
    mainSupplyGood};

  // two stages per pin, first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gSync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          syncA_r[gi] <= 1'b0;
          syncB_r[gi] <= 1'b0;
        end else begin
          syncA_r[gi] <= pinRaw[gi];
          syncB_r[gi] <= syncA_r[gi];
        end
      end
    end
  endgenerate

  logic mainGood;
  logic mainLow;
  logic batFirstLow;
  logic batSecondLow;
  logic mainRise;
  logic mainFall;
  logic detectStrobe;
  assign mainGood = syncB_r[0];
  assign mainLow = syncB_r[1];
  assign batFirstLow = syncB_r[2];
  assign batSecondLow = syncB_r[3];
  assign mainRise = mainGood && !mainGoodDly_r;
  assign mainFall = !mainGood && mainGoodDly_r;
  // R14: minute tick or sense trigger, only on main supply
  assign detectStrobe = mainGood && (secondsAt59 || tempSenseTrigger);

  // delayed main-good for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mainGoodDly_r <= 1'b0;
    end else begin
      mainGoodDly_r <= mainGood;
    end
  end

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic waitReq_r;
  logic [SMTC_DATA_W-1:0] readData_r;
  logic busReq;
  logic accept;
  logic wrAccept;
  logic rdAccept;
  logic [5:0] regIdx;
  logic lane0;
  assign busReq = avsRead || avsWrite;
  assign accept = busReq && !waitReq_r;
  assign wrAccept = accept && avsWrite && lane0;
  assign rdAccept = avsRead && waitReq_r; // read latched, clear lands here
  assign regIdx = avsAddress[7:2];
  assign lane0 = avsByteEnable[0];
  assign avsWaitRequest = waitReq_r;
  assign avsReadData = readData_r;

  logic wrMain;
  logic wrBat;
  logic wrMask;
  logic rdStatus;
  assign wrMain = wrAccept && regIdx == SMTC_IDX_MAIN_CTRL;
  assign wrBat = wrAccept && regIdx == SMTC_IDX_BAT_CTRL;
  assign wrMask = wrAccept && regIdx == SMTC_IDX_MASK;
  assign rdStatus = rdAccept && regIdx == SMTC_IDX_STATUS;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic clearStampsBit_r;
  logic [2:0] mainSupplyTripSel_r;
  logic batteryDisconnectBit_r;
  logic [2:0] firstBatteryTripSel_r;
  logic [2:0] secondBatteryTripSel_r;
  logic [5:0] analogTrimCode_r;
  logic [1:0] coarseDigitalTrimCode_r;
  logic [SMTC_ST_W-1:0] mask_r;
  logic disconnectNxt;
  logic [7:0] mainCtrlView;
  logic [7:0] batCtrlView;
  logic [7:0] trimView;

  // R6: main return after a loss clears the request
  assign disconnectNxt = mainRise ? 1'b0 :
    wrBat ? avsWriteData[SMTC_DISCONNECT_POS] : batteryDisconnectBit_r;
  // R16: bits 6..3 held at zero
  assign mainCtrlView = {clearStampsBit_r, 4'h0, mainSupplyTripSel_r};
  assign batCtrlView = {1'b0, batteryDisconnectBit_r, firstBatteryTripSel_r,
    secondBatteryTripSel_r};
  assign trimView = {coarseDigitalTrimCode_r, analogTrimCode_r};

  // R2: clear bit resets inactive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clearStampsBit_r <= SMTC_MAIN_CTRL_RST[SMTC_CLR_STAMPS_POS];
      mainSupplyTripSel_r <= SMTC_MAIN_CTRL_RST[2:0];
    end else if (wrMain) begin
      // R3: main threshold selector
      clearStampsBit_r <= avsWriteData[SMTC_CLR_STAMPS_POS];
      mainSupplyTripSel_r <= avsWriteData[SMTC_MAIN_SEL_LSB +: 3];
    end
  end

  // R5: disconnect request and battery selectors
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      batteryDisconnectBit_r <= SMTC_BAT_CTRL_RST[SMTC_DISCONNECT_POS];
      firstBatteryTripSel_r <= SMTC_BAT_CTRL_RST[5:3];
      secondBatteryTripSel_r <= SMTC_BAT_CTRL_RST[2:0];
      mask_r <= SMTC_MASK_RST;
    end else begin
      batteryDisconnectBit_r <= disconnectNxt;
      if (wrBat) begin
        // R7: first selector bits 5..3
        firstBatteryTripSel_r <= avsWriteData[SMTC_FIRST_SEL_LSB +: 3];
        // R8: second selector bits 2..0
        secondBatteryTripSel_r <= avsWriteData[SMTC_SECOND_SEL_LSB +: 3];
      end
      if (wrMask) begin
        mask_r <= avsWriteData[SMTC_ST_W-1:0];
      end
    end
  end

  // R9: factory presets recalled at power-up, no write path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analogTrimCode_r <= ATRIM_PRESET;
      coarseDigitalTrimCode_r <= DTRIM_PRESET;
    end else begin
      analogTrimCode_r <= analogTrimCode_r;
      coarseDigitalTrimCode_r <= coarseDigitalTrimCode_r;
    end
  end

  // ****************************************************************
  // switchover stamps, level flags and status
  // ****************************************************************
  logic [31:0] stampMainToBackup_r;
  logic [31:0] stampBackupToMain_r;
  logic batteryLowFirstFlag_r;
  logic batteryLowSecondFlag_r;
  logic mainSupplyLowFlag_r;
  logic [SMTC_ST_W-1:0] status_r;
  logic [SMTC_ST_W-1:0] statusSet;
  logic [SMTC_ST_W-1:0] statusNxt;
  logic clearStamps;

  // R1: a write with the clear bit set wipes both stamps
  assign clearStamps = wrMain && avsWriteData[SMTC_CLR_STAMPS_POS];
  // R4: main low raises its flag while the comparator trips
  assign statusSet = {mainRise, mainFall,
    detectStrobe && batSecondLow, detectStrobe && batFirstLow, mainLow};
  // set wins over the read clear, no set lost after the data latch
  assign statusNxt = (rdStatus ? '0 : status_r) | statusSet;

  // stamps capture the time at each switchover, capture beats clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stampMainToBackup_r <= 32'h0000_0000;
      stampBackupToMain_r <= 32'h0000_0000;
    end else begin
      if (mainFall) begin
        stampMainToBackup_r <= timeNow;
      end else if (clearStamps) begin
        stampMainToBackup_r <= 32'h0000_0000;
      end
      if (mainRise) begin
        stampBackupToMain_r <= timeNow;
      end else if (clearStamps) begin
        stampBackupToMain_r <= 32'h0000_0000;
      end
    end
  end

  // R15: battery flags follow the comparators at each detection cycle, main low flag every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      batteryLowFirstFlag_r <= 1'b0;
      batteryLowSecondFlag_r <= 1'b0;
      mainSupplyLowFlag_r <= 1'b0;
      status_r <= '0;
    end else begin
      if (detectStrobe) begin
        batteryLowFirstFlag_r <= batFirstLow;
        batteryLowSecondFlag_r <= batSecondLow;
      end
      mainSupplyLowFlag_r <= mainLow;
      status_r <= statusNxt;
    end
  end

  // ****************************************************************
  // read mux and bus handshake
  // ****************************************************************
  logic [SMTC_DATA_W-1:0] readMux;
  assign readMux =
    (regIdx == SMTC_IDX_MAIN_CTRL) ? {24'h000000, mainCtrlView} :
    (regIdx == SMTC_IDX_BAT_CTRL) ? {24'h000000, batCtrlView} :
    (regIdx == SMTC_IDX_TRIM) ? {24'h000000, trimView} :
    (regIdx == SMTC_IDX_STATUS) ? {27'h0, status_r} :
    (regIdx == SMTC_IDX_MASK) ? {27'h0, mask_r} :
    (regIdx == SMTC_IDX_STAMP_M2B) ? stampMainToBackup_r :
    (regIdx == SMTC_IDX_STAMP_B2M) ? stampBackupToMain_r :
    (regIdx == SMTC_IDX_LEVEL) ? {29'h0, mainSupplyLowFlag_r,
      batteryLowSecondFlag_r, batteryLowFirstFlag_r} :
    32'h0000_0000;

  // one wait cycle, then a single ready cycle per request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitReq_r <= 1'b1;
      readData_r <= 32'h0000_0000;
    end else begin
      waitReq_r <= !(busReq && waitReq_r);
      if (busReq && waitReq_r) begin
        readData_r <= avsRead ? readMux : 32'h0000_0000;
      end
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
      batteryDisconnect <= 1'b0;
    end else begin
      irq <= |(statusNxt & mask_r);
      batteryDisconnect <= disconnectNxt;
    end
  end

  // ****************************************************************
  // threshold decoders and trim
  // ****************************************************************
  smtc_trip_decode #(.TABLE(SMTC_TBL_MAIN)) uMainDec (
    .clk(clk), .rst_n(rst_n), .tripSel(mainSupplyTripSel_r),
    .thresholdMv_r(mainTripMv), .thresholdValid_r(mainTripValid));
  smtc_trip_decode #(.TABLE(SMTC_TBL_FIRST)) uFirstDec (
    .clk(clk), .rst_n(rst_n), .tripSel(firstBatteryTripSel_r),
    .thresholdMv_r(firstTripMv), .thresholdValid_r(firstTripValid));
  smtc_trip_decode #(.TABLE(SMTC_TBL_SECOND)) uSecondDec (
    .clk(clk), .rst_n(rst_n), .tripSel(secondBatteryTripSel_r),
    .thresholdMv_r(secondTripMv), .thresholdValid_r(secondTripValid));
  smtc_trim uTrim (
    .clk(clk), .rst_n(rst_n), .analogTrimCode(analogTrimCode_r),
    .coarseDigitalTrimCode(coarseDigitalTrimCode_r),
    .trimHalfPpm_r(trimHalfPpm), .insertPulse_r(insertPulse),
    .skipPulse_r(skipPulse));

  // ****************************************************************
  // checks
  // ****************************************************************
  wait_release_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (busReq && waitReq_r) |=> !waitReq_r ##1 waitReq_r)
    else $error("wait request not released for exactly one cycle");
  stamp_clear_a: assert property ( // R1
    @(posedge clk) disable iff (!rst_n)
    (clearStamps && !mainFall && !mainRise) |=>
      stampMainToBackup_r == 32'h0 && stampBackupToMain_r == 32'h0)
    else $error("stamps not cleared");
  reserved_zero_a: assert property ( // R16
    @(posedge clk) disable iff (!rst_n)
    wrMain |=> mainCtrlView[6:3] == 4'h0)
    else $error("reserved main control bits not zero");
  trim_fixed_a: assert property ( // R9
    @(posedge clk) disable iff (!rst_n)
    wrAccept |=> analogTrimCode_r == ATRIM_PRESET &&
      coarseDigitalTrimCode_r == DTRIM_PRESET)
    else $error("trim code changed by a write");
  reconnect_a: assert property ( // R6
    @(posedge clk) disable iff (!rst_n)
    mainRise |=> !batteryDisconnectBit_r && !batteryDisconnect)
    else $error("battery not reconnected on main return");
  main_low_a: assert property ( // R4
    @(posedge clk) disable iff (!rst_n)
    mainLow |=> status_r[SMTC_ST_MAIN_LOW] && mainSupplyLowFlag_r)
    else $error("main low flag not set");
  bat_flag_a: assert property ( // R15
    @(posedge clk) disable iff (!rst_n)
    detectStrobe |=> batteryLowFirstFlag_r == $past(batFirstLow))
    else $error("first battery flag missed its detection cycle");
  bat_hold_a: assert property ( // R14
    @(posedge clk) disable iff (!rst_n)
    !detectStrobe |=> $stable(batteryLowFirstFlag_r))
    else $error("first battery flag moved outside detection");
  disconnect_set_a: assert property ( // R5
    @(posedge clk) disable iff (!rst_n)
    (wrBat && avsWriteData[SMTC_DISCONNECT_POS] && !mainRise) |=>
      batteryDisconnect)
    else $error("disconnect request not raised");
  irq_level_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ##1 (irq == |($past(statusNxt) & $past(mask_r))))
    else $error("interrupt does not follow masked status");
endmodule // smtc_supply_cfg

// ---- tb/smtc_front_model.sv ----
// analog front end model: supply comparators and supply present pin
module smtc_front_model (
  input wire logic clk,
  input wire logic [12:0] mainMv,
  input wire logic [12:0] batMv,
  input wire logic [12:0] mainTripMv,
  input wire logic [12:0] firstTripMv,
  input wire logic [12:0] secondTripMv,
  output logic mainSupplyGood = 1'b0,
  output logic mainBelowTrip = 1'b0,
  output logic batBelowFirstTrip = 1'b0,
  output logic batBelowSecondTrip = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // comparators settle one edge after a level moves, like real ones lag
  always @(posedge clk) begin
    mainSupplyGood <= mainMv != 13'h0;
    mainBelowTrip <= mainMv < mainTripMv;
    batBelowFirstTrip <= batMv < firstTripMv;
    batBelowSecondTrip <= batMv < secondTripMv;
  end
endmodule // smtc_front_model

// ---- tb/smtc_supply_cfg_tb.sv ----
// self-checking bench of the supply monitor configuration bank
module smtc_supply_cfg_tb import smtc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, avsRead, avsWrite, secondsAt59, tempSenseTrigger;
  logic [7:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, timeNow, rnd;
  logic [3:0] avsByteEnable;
  logic avsWaitRequest, mainSupplyGood, mainBelowTrip, batBelowFirstTrip;
  logic batBelowSecondTrip, mainTripValid, firstTripValid, secondTripValid;
  logic [12:0] mainTripMv, firstTripMv, secondTripMv, mainMv, batMv;
  logic batteryDisconnect, insertPulse, skipPulse, irq;
  logic signed [7:0] trimHalfPpm;
  logic [31:0] expQ[$];
  int checks, miscompares;
  // ********
  // expected thresholds in mV, zero for reserved codes
  // ********
  logic [12:0] tblM [8] = '{13'h8f7, 13'h9f6, 13'haf5, 13'hbf4, 13'h109a,
    13'h1243, 13'h0, 13'h0};
  logic [12:0] tblF [8] = '{13'h84d, 13'h8f7, 13'h9f6, 13'haf5, 13'hbf4,
    13'h109a, 13'h1243, 13'h0};
  logic [12:0] tblS [8] = '{13'h753, 13'h7e9, 13'h8ca, 13'h9ab, 13'ha8c,
    13'hea6, 13'h101d, 13'h0};

  smtc_supply_cfg #(.ATRIM_PRESET(6'h00), .DTRIM_PRESET(2'h1)) dut (.clk,
    .rst_n, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
    .avsReadData, .avsWaitRequest, .mainSupplyGood, .mainBelowTrip,
    .batBelowFirstTrip, .batBelowSecondTrip, .secondsAt59, .tempSenseTrigger,
    .timeNow, .mainTripMv, .mainTripValid, .firstTripMv, .firstTripValid,
    .secondTripMv, .secondTripValid, .batteryDisconnect, .trimHalfPpm,
    .insertPulse, .skipPulse, .irq);

  smtc_front_model front (.clk, .mainMv, .batMv, .mainTripMv, .firstTripMv,
    .secondTripMv, .mainSupplyGood, .mainBelowTrip, .batBelowFirstTrip,
    .batBelowSecondTrip);

  // clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // bus write: hold until waitrequest is sampled low
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    avsAddress <= {idx, 2'b00};
    avsWriteData <= {24'h0, d};
    avsWrite <= 1'b1;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    avsWrite <= 1'b0;
    @(posedge clk);
  endtask

  // bus read: note the expectation, the monitor compares
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    expQ.push_back(exp);
    avsAddress <= {idx, 2'b00};
    avsRead <= 1'b1;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    avsRead <= 1'b0;
    @(posedge clk);
  endtask

  // read data taken at the edge where waitrequest is low
  always @(posedge clk) begin
    if (avsRead && avsWaitRequest === 1'b0)
      check(avsReadData, expQ.pop_front());
  end

  task automatic pulse(input bit which);
    if (which) secondsAt59 <= 1'b1;
    else tempSenseTrigger <= 1'b1;
    @(posedge clk);
    secondsAt59 <= 1'b0;
    tempSenseTrigger <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  // ********
  // main sequence
  // ********
  initial begin
    {rst_n, avsRead, avsWrite, secondsAt59, tempSenseTrigger} = 5'h0;
    avsAddress = 8'h0;
    avsWriteData = 32'h0;
    avsByteEnable = 4'h1;
    rnd = 32'h43;
    timeNow = 32'h0;
    mainMv = 13'hce4;
    batMv = 13'hbb8;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd(SMTC_IDX_STATUS, 32'h10);
    rd(SMTC_IDX_STATUS, 32'h0);
    rd(SMTC_IDX_MAIN_CTRL, 32'h0);
    rd(SMTC_IDX_BAT_CTRL, 32'h0);
    rd(6'h00, 32'h0);
    check({24'h0, trimHalfPpm}, 32'h7d);
    check({30'h0, insertPulse, skipPulse}, 32'h2);
    // trim written while temperature sensing stays off
    wr(SMTC_IDX_TRIM, 8'hff);
    rd(SMTC_IDX_TRIM, 32'h40);
    wr(SMTC_IDX_MAIN_CTRL, 8'hff);
    rd(SMTC_IDX_MAIN_CTRL, 32'h87);
    avsByteEnable <= 4'h0;
    wr(SMTC_IDX_MAIN_CTRL, 8'h02);
    avsByteEnable <= 4'h1;
    rd(SMTC_IDX_MAIN_CTRL, 32'h87);
    for (int i = 0; i < 8; i++) begin
      wr(SMTC_IDX_MAIN_CTRL, 8'(i));
      wr(SMTC_IDX_BAT_CTRL, 8'(i * 9));
      repeat (3) @(posedge clk);
      check({19'h0, mainTripMv}, {19'h0, tblM[i]});
      check({19'h0, firstTripMv}, {19'h0, tblF[i]});
      check({19'h0, secondTripMv}, {19'h0, tblS[i]});
      check({29'h0, mainTripValid, firstTripValid, secondTripValid},
        {29'h0, tblM[i] != 0, tblF[i] != 0, tblS[i] != 0});
    end
    wr(SMTC_IDX_MAIN_CTRL, 8'h00);
    wr(SMTC_IDX_BAT_CTRL, 8'h10);
    batMv <= 13'h960;
    repeat (5) @(posedge clk);
    rd(SMTC_IDX_LEVEL, 32'h0);
    pulse(1'b1);
    rd(SMTC_IDX_LEVEL, 32'h1);
    rd(SMTC_IDX_STATUS, 32'h3);
    batMv <= 13'hbb8;
    repeat (5) @(posedge clk);
    pulse(1'b0);
    rd(SMTC_IDX_LEVEL, 32'h0);
    mainMv <= 13'h7d0;
    repeat (6) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(SMTC_IDX_MASK, 8'h01);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    mainMv <= 13'hce4;
    repeat (5) @(posedge clk);
    rd(SMTC_IDX_STATUS, 32'h1);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    timeNow <= rnd;
    wr(SMTC_IDX_BAT_CTRL, 8'h50);
    repeat (3) @(posedge clk);
    check({31'h0, batteryDisconnect}, 32'h1);
    mainMv <= 13'h0;
    repeat (6) @(posedge clk);
    rd(SMTC_IDX_STAMP_M2B, rnd);
    rnd = lfsr(rnd);
    timeNow <= rnd;
    mainMv <= 13'hce4;
    repeat (6) @(posedge clk);
    check({31'h0, batteryDisconnect}, 32'h0);
    rd(SMTC_IDX_BAT_CTRL, 32'h10);
    rd(SMTC_IDX_STAMP_B2M, rnd);
    wr(SMTC_IDX_MAIN_CTRL, 8'h80);
    rd(SMTC_IDX_STAMP_M2B, 32'h0);
    rd(SMTC_IDX_STAMP_B2M, 32'h0);
    rd(SMTC_IDX_MAIN_CTRL, 32'h80);
    tally_and_finish();
  end
endmodule // smtc_supply_cfg_tb
